// [smsc_pkg.sv]
// Constants, types and helpers shared by the serial port core
//
// Overview of operation
// - Slave select rising in slave mode resets shifting, dropping partial bits.
// - Slave select is input in slave mode; MISO drives only if enabled.
// - While slave select is high the slave ignores incoming serial data.
// - Master with select pin as output: pin is plain output, no effect.
// - Select driven low as input in master mode forces slave mode.
// - That forced change to slave sets the transfer-complete flag.
// - Data shifts out on one clock edge and is sampled on the other.
// - Polarity one idles clock high; zero idles clock low.
// - Phase zero samples on leading edge; phase one on trailing edge.
// - Interrupt requested when flag, interrupt enable and global enable set.
// - No serial operation unless the port enable bit is one.
// - Bit order one sends LSB first; zero sends MSB first.
// - Normal speed master divides clock by 4, 16, 64 or 128.
// - Double speed master divides clock by 2, 8, 32 or 64.
// - Transfer-complete flag sets each time a byte transfer finishes.
// - Transfer-complete flag clears when the interrupt vector is entered.
// - Status read with flag set, then data access, clears the flag.
// - Status bits 7 to 1 read-only, reset zero; bit 0 writable.
// - Data write starts transmission; data read returns receive buffer.
// - Data write during transfer sets collision flag; cleared only by status read then data access.
// - Transmit single buffered, receive double buffered; late reads lose bytes.
package smsc_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [7:0] SMSC_OFF_CTRL = 8'h00;
	localparam logic [7:0] SMSC_OFF_STAT = 8'h04;
	localparam logic [7:0] SMSC_OFF_DATA = 8'h08;
	localparam logic [7:0] SMSC_OFF_PDIR = 8'h0c;
	localparam logic [7:0] SMSC_CTRL_RST = 8'h00;
	localparam logic [7:0] SMSC_DATA_RST = 8'h00;
	localparam logic [4:0] SMSC_PDIR_RST = 5'h00;

	// Pin direction register fields
	localparam int SMSC_PD_MOSI = 0;
	localparam int SMSC_PD_MISO = 1;
	localparam int SMSC_PD_SCK = 2;
	localparam int SMSC_PD_SS = 3;
	localparam int SMSC_PD_SSVAL = 4;

	// Status register fields
	localparam int SMSC_ST_TCF = 7;
	localparam int SMSC_ST_WRITE_COLLISION_FLAG = 6;
	localparam int SMSC_ST_DBL = 0;

	// ********************************
	// Timing
	// ********************************
	// Half periods of SCK in clock cycles, per rate code
	localparam logic [6:0] SMSC_HALF_N0 = 7'h02;
	localparam logic [6:0] SMSC_HALF_N1 = 7'h08;
	localparam logic [6:0] SMSC_HALF_N2 = 7'h20;
	localparam logic [6:0] SMSC_HALF_N3 = 7'h40;
	localparam logic [6:0] SMSC_HALF_D0 = 7'h01;
	localparam logic [6:0] SMSC_HALF_D1 = 7'h04;
	localparam logic [6:0] SMSC_HALF_D2 = 7'h10;
	localparam logic [6:0] SMSC_HALF_D3 = 7'h20;
	// Sixteen clock edges carry one byte
	localparam logic [3:0] SMSC_LAST_EDGE = 4'hf;

	// ********************************
	// Types
	// ********************************
	typedef struct packed {
		logic ie;
		logic en;
		logic lsb;
		logic mst;
		logic clock_polarity_bit;
		logic clock_phase_bit;
		logic [1:0] rate;
	} smsc_ctrl_t;

	typedef struct packed {
		logic o;
		logic oe;
	} smsc_pin_t;

	typedef enum logic [1:0] {SMSC_IDLE, SMSC_RUN, SMSC_DONE} smsc_state_t;

	function automatic logic [6:0] smsc_half(input logic dbl,
		input logic [1:0] rate);
		logic [6:0] h;
		h = SMSC_HALF_N0;
		case ({dbl, rate})
			3'h0: h = SMSC_HALF_N0;
			3'h1: h = SMSC_HALF_N1;
			3'h2: h = SMSC_HALF_N2;
			3'h3: h = SMSC_HALF_N3;
			3'h4: h = SMSC_HALF_D0;
			3'h5: h = SMSC_HALF_D1;
			3'h6: h = SMSC_HALF_D2;
			default: h = SMSC_HALF_D3;
		endcase
		return h;
	endfunction

	function automatic logic [7:0] smsc_shift(input logic [7:0] sr,
		input logic b, input logic lsb);
		return lsb ? {b, sr[7:1]} : {sr[6:0], b};
	endfunction

endpackage

// [smsc_clkdiv.sv]
// Master SCK half-period tick generator
`timescale 1ns/1ns
module smsc_clkdiv
	import smsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [6:0] half,
	output logic tick
);
	logic [6:0] cnt_ff;
	logic [6:0] nxt_cnt;

	assign tick = run && (cnt_ff == half - 7'h01);
	assign nxt_cnt = (!run || tick) ? 7'h00 : cnt_ff + 7'h01;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 7'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// [smsc_edge.sv]
// Slave SCK synchroniser and edge detector
`timescale 1ns/1ns
module smsc_edge
	import smsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sck_i,
	output logic sck_edge
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;

	// Either edge; leading or trailing is decided by the edge count
	assign sck_edge = s2_ff ^ s3_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= sck_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
endmodule

// [smsc_core.sv]
// Master/slave byte-wide serial port with APB register access
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
module smsc_core
	import smsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic gie,
	input wire logic irq_ack,
	output logic irq,
	input wire logic sck_i,
	output smsc_pin_t sck_out,
	input wire logic mosi_i,
	output smsc_pin_t mosi_out,
	input wire logic miso_i,
	output smsc_pin_t miso_out,
	input wire logic ss_n_i,
	output smsc_pin_t ss_n_out
);

	// ********************************
	// State
	// ********************************
	smsc_ctrl_t ctrl_ff;
	smsc_ctrl_t nxt_ctrl;
	smsc_state_t state_ff;
	smsc_state_t nxt_state;
	logic dbl_ff;
	logic tcf_ff;
	logic write_collision_flag_ff;
	logic arm_ff;
	logic [4:0] pdir_ff;
	logic [7:0] sr_ff;
	logic [7:0] nxt_sr;
	logic [7:0] rxbuf_ff;
	logic samp_ff;
	logic pend_ff;
	logic [3:0] cnt_ff;
	logic sck_ff;

	// ********************************
	// APB decode
	// ********************************
	logic acc;
	logic wr;
	logic rd;
	logic sel_ctrl;
	logic sel_stat;
	logic sel_data;
	logic sel_pdir;
	logic mapped;
	logic [7:0] stat_rd;

	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign sel_ctrl = paddr == SMSC_OFF_CTRL;
	assign sel_stat = paddr == SMSC_OFF_STAT;
	assign sel_data = paddr == SMSC_OFF_DATA;
	assign sel_pdir = paddr == SMSC_OFF_PDIR;
	assign mapped = sel_ctrl || sel_stat || sel_data || sel_pdir;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign stat_rd = {tcf_ff, write_collision_flag_ff, 5'h00, dbl_ff};
	assign prdata = !rd ? 32'h0000_0000 :
		sel_ctrl ? {24'h00_0000, ctrl_ff} :
		sel_stat ? {24'h00_0000, stat_rd} :
		sel_data ? {24'h00_0000, rxbuf_ff} :
		sel_pdir ? {27'h000_0000, pdir_ff} : 32'h0000_0000;

	// ********************************
	// Mode and transfer control
	// ********************************
	logic en;
	logic mst;
	logic mode_fault;
	logic slave_act;
	logic slave_rst;
	logic busy;
	logic data_wr;
	logic data_acc;
	logic start;
	logic tick;
	logic sck_edge;
	logic edge_go;
	logic leading;
	logic sample_e;
	logic setup_e;
	logic abort;
	logic done;
	logic in_bit;
	logic out_bit;
	logic [7:0] sr_shifted;
	logic tcf_clr;

	assign en = ctrl_ff.en;
	assign mst = ctrl_ff.mst;
	// Another master pulled select low while it is an input
	assign mode_fault = en && mst && !pdir_ff[SMSC_PD_SS] && !ss_n_i;
	assign slave_act = en && !mst && !ss_n_i;
	assign slave_rst = en && !mst && ss_n_i;
	assign busy = state_ff != SMSC_IDLE;
	assign data_wr = wr && sel_data;
	assign data_acc = acc && sel_data;
	assign start = data_wr && !busy && en && mst && !mode_fault;
	assign done = state_ff == SMSC_DONE;
	assign abort = !en || mode_fault || slave_rst;
	// Slave edges are ignored while select is high
	assign edge_go = (state_ff == SMSC_RUN && (mst ? tick : sck_edge &&
		slave_act)) || (state_ff == SMSC_IDLE && slave_act &&
		sck_edge);
	assign leading = !cnt_ff[0];
	assign sample_e = edge_go && (leading ^ ctrl_ff.clock_phase_bit);
	assign setup_e = edge_go && !(leading ^ ctrl_ff.clock_phase_bit);
	assign in_bit = mst ? miso_i : mosi_i;
	assign out_bit = ctrl_ff.lsb ? sr_ff[0] : sr_ff[7];
	assign sr_shifted = smsc_shift(sr_ff, samp_ff, ctrl_ff.lsb);
	assign tcf_clr = irq_ack || (arm_ff && data_acc);

	smsc_clkdiv u_clkdiv (
		.pclk(pclk),
		.presetn(presetn),
		.run(state_ff == SMSC_RUN && mst),
		.half(smsc_half(dbl_ff, ctrl_ff.rate)),
		.tick(tick)
	);

	smsc_edge u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.sck_i(sck_i),
		.sck_edge(sck_edge)
	);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SMSC_IDLE: begin
				if (start || (edge_go && !abort)) begin
					nxt_state = SMSC_RUN;
				end
			end
			SMSC_RUN: begin
				if (abort) begin
					nxt_state = SMSC_IDLE;
				end else if (edge_go && cnt_ff == SMSC_LAST_EDGE) begin
					nxt_state = SMSC_DONE;
				end
			end
			SMSC_DONE: nxt_state = SMSC_IDLE;
			default: nxt_state = SMSC_IDLE;
		endcase
	end

	// Shift register: one byte, loaded only when idle (single buffer)
	always_comb begin
		nxt_sr = sr_ff;
		if (data_wr && !busy) begin
			nxt_sr = pwdata[7:0];
		end else if ((setup_e || done) && pend_ff) begin
			nxt_sr = sr_shifted;
		end
	end

	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr && sel_ctrl) begin
			nxt_ctrl = smsc_ctrl_t'(pwdata[7:0]);
		end
		if (mode_fault) begin
			nxt_ctrl.mst = 1'b0;
		end
	end

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= smsc_ctrl_t'(SMSC_CTRL_RST);
			pdir_ff <= SMSC_PDIR_RST;
			dbl_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			if (wr && sel_pdir) begin
				pdir_ff <= pwdata[4:0];
			end
			if (wr && sel_stat) begin
				dbl_ff <= pwdata[SMSC_ST_DBL];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcf_ff <= 1'b0;
			write_collision_flag_ff <= 1'b0;
			arm_ff <= 1'b0;
		end else begin
			// Setting wins over a clear in the same cycle
			tcf_ff <= done || mode_fault || (tcf_ff && !tcf_clr);
			write_collision_flag_ff <= (data_wr && busy) ||
				(write_collision_flag_ff && !(arm_ff && data_acc));
			if (data_acc) begin
				arm_ff <= 1'b0;
			end else if (rd && sel_stat && (tcf_ff || write_collision_flag_ff)) begin
				arm_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= SMSC_IDLE;
			cnt_ff <= 4'h0;
			pend_ff <= 1'b0;
			samp_ff <= 1'b0;
			sck_ff <= 1'b0;
			sr_ff <= SMSC_DATA_RST;
			rxbuf_ff <= SMSC_DATA_RST;
		end else begin
			state_ff <= nxt_state;
			sr_ff <= nxt_sr;
			if (abort || nxt_state == SMSC_IDLE) begin
				cnt_ff <= 4'h0;
				pend_ff <= 1'b0;
			end else if (edge_go) begin
				cnt_ff <= cnt_ff + 4'h1;
				pend_ff <= sample_e;
			end
			if (sample_e) begin
				samp_ff <= in_bit;
			end
			if (done) begin
				rxbuf_ff <= pend_ff ? sr_shifted : sr_ff;
			end
			if (state_ff == SMSC_RUN && mst && tick && !abort) begin
				sck_ff <= !sck_ff;
			end else if (state_ff != SMSC_RUN) begin
				sck_ff <= ctrl_ff.clock_polarity_bit;
			end
		end
	end

	// ********************************
	// Pins and interrupt
	// ********************************
	assign irq = ctrl_ff.ie && tcf_ff && gie;
	assign sck_out.o = sck_ff;
	assign sck_out.oe = en && mst && pdir_ff[SMSC_PD_SCK];
	assign mosi_out.o = out_bit;
	assign mosi_out.oe = en && mst && pdir_ff[SMSC_PD_MOSI];
	assign miso_out.o = out_bit;
	// Tri-stated while unselected so shared slaves do not fight
	assign miso_out.oe = slave_act && pdir_ff[SMSC_PD_MISO];
	// As master output the select pin is plain port output
	assign ss_n_out.o = pdir_ff[SMSC_PD_SSVAL];
	assign ss_n_out.oe = en && mst && pdir_ff[SMSC_PD_SS];

	// ********************************
	// Assertions
	// ********************************
	property p_done_flag;
		@(posedge pclk) disable iff (!presetn)
		done |=> tcf_ff;
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("transfer-complete flag not set after byte");

	property p_fault;
		@(posedge pclk) disable iff (!presetn)
		mode_fault |=> !ctrl_ff.mst && tcf_ff && state_ff == SMSC_IDLE;
	endproperty
	a_fault: assert property (p_fault)
		else $error("forced slave change did not happen");

	property p_ss_rst;
		@(posedge pclk) disable iff (!presetn)
		slave_rst |=> cnt_ff == 4'h0 && state_ff == SMSC_IDLE;
	endproperty
	a_ss_rst: assert property (p_ss_rst)
		else $error("slave logic not reset by select high");

	property p_disabled;
		@(posedge pclk) disable iff (!presetn)
		!en && !nxt_ctrl.en |=> state_ff == SMSC_IDLE && !sck_out.oe &&
			!miso_out.oe;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("serial activity while disabled");

	property p_idle_sck;
		@(posedge pclk) disable iff (!presetn)
		state_ff == SMSC_IDLE && $past(state_ff) == SMSC_IDLE
			|-> sck_ff == $past(ctrl_ff.clock_polarity_bit);
	endproperty
	a_idle_sck: assert property (p_idle_sck)
		else $error("sck idle level wrong");

	property p_write_collision_flag;
		@(posedge pclk) disable iff (!presetn)
		data_wr && busy |=> write_collision_flag_ff;
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag)
		else $error("write collision not flagged");

	property p_ack_clr;
		@(posedge pclk) disable iff (!presetn)
		irq_ack && !done && !mode_fault |=> !tcf_ff;
	endproperty
	a_ack_clr: assert property (p_ack_clr)
		else $error("flag not cleared by vector entry");

	property p_miso;
		@(posedge pclk) disable iff (!presetn)
		miso_out.oe |-> !ss_n_i && !mst;
	endproperty
	a_miso: assert property (p_miso)
		else $error("miso driven while unselected");

	property p_rx;
		@(posedge pclk) disable iff (!presetn)
		done && pend_ff |=> rxbuf_ff == $past(sr_shifted);
	endproperty
	a_rx: assert property (p_rx)
		else $error("receive buffer not updated");

	property p_stat_ro;
		@(posedge pclk) disable iff (!presetn)
		rd && sel_stat |-> prdata[5:1] == 5'h00;
	endproperty
	a_stat_ro: assert property (p_stat_ro)
		else $error("reserved status bits not zero");

	property p_half;
		@(posedge pclk) disable iff (!presetn)
		mst && state_ff == SMSC_RUN && tick && !dbl_ff &&
			ctrl_ff.rate == 2'h0 && !abort && cnt_ff != SMSC_LAST_EDGE
			|=> !tick ##1 tick || abort;
	endproperty
	a_half: assert property (p_half)
		else $error("sck half period wrong");

	c_master: cover property (@(posedge pclk) disable iff (!presetn)
		done && mst);
	c_slave: cover property (@(posedge pclk) disable iff (!presetn)
		done && !mst);
	c_fault: cover property (@(posedge pclk) disable iff (!presetn)
		mode_fault);
	c_write_collision_flag: cover property (@(posedge pclk) disable iff (!presetn)
		data_wr && busy);

endmodule

// [smsc_peer.sv]
// Behavioural far-side serial slave used while the core is master
`timescale 1ns/1ns
module smsc_peer (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic clock_polarity_bit,
	input wire logic clock_phase_bit,
	input wire logic lsb,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	// ****************
	// Shift logic
	// ****************
	int n = 0;
	logic hold = 1'b0;
	logic [2:0] idx;
	logic cur;
	initial rx = 8'h00;
	assign idx = 3'(clock_phase_bit ? n - 1 : n);
	assign cur = tx[lsb ? idx : 3'd7 - idx];
	// A released line shows the inverse of its last bit, never a stale copy
	assign miso = sel_n ? hold : cur;
	always @(posedge sel_n) hold = ~cur;
	always @(negedge sel_n) n = 0;
	always @(sck) begin
		if (!sel_n && ((sck != clock_polarity_bit) ^ clock_phase_bit)) begin
			rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		end else if (!sel_n) begin
			n = n + 1;
		end
	end
endmodule

// [smsc_core_tb_top.sv]
// Self-checking testbench for the serial port core
`timescale 1ns/1ns
module smsc_core_tb_top;
	import smsc_pkg::*;
	// ****************
	// Signals
	// ****************
	logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, ptx = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_v;
	logic pready, pslverr, irq, err_v, gie = 1'b0, irq_ack = 1'b0;
	logic tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss_n = 1'b1;
	logic pcpol = 1'b0, pcpha = 1'b0, plsb = 1'b0;
	smsc_pin_t sck_out, mosi_out, miso_out, ss_n_out;
	logic peer_miso;
	logic [7:0] prx;
	wire sck_w = sck_out.oe ? sck_out.o : tb_sck;
	wire mosi_w = mosi_out.oe ? mosi_out.o : tb_mosi;
	wire ss_w = ss_n_out.oe ? ss_n_out.o : tb_ss_n;
	wire miso_w = miso_out.oe ? miso_out.o : peer_miso;
	int num_errors = 0, check_count = 0, i, k;
	int dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};

	smsc_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .gie(gie),
		.irq_ack(irq_ack), .irq(irq), .sck_i(sck_w), .sck_out(sck_out),
		.mosi_i(mosi_w), .mosi_out(mosi_out), .miso_i(miso_w),
		.miso_out(miso_out), .ss_n_i(ss_w), .ss_n_out(ss_n_out));
	smsc_peer peer (.sck(sck_w), .mosi(mosi_w), .sel_n(ss_w), .clock_polarity_bit(pcpol),
		.clock_phase_bit(pcpha), .lsb(plsb), .tx(ptx), .miso(peer_miso), .rx(prx));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ****************
	// Tasks
	// ****************
	task automatic end_sim;
		if (num_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd_v, e);
	endtask

	// Polls are bounded so a dead flag ends in a mismatch, not a hang
	task automatic wait_tcf;
		k = 0;
		do begin
			apb(1'b0, SMSC_OFF_STAT, 32'h0);
			k++;
		end while (rd_v[SMSC_ST_TCF] !== 1'b1 && k < 600);
	endtask

	// Bench acts as external master; phases kept well above two clocks
	task automatic sbyte(input logic [7:0] d, input int nb, input logic cm,
		input logic [7:0] e);
		for (int j = 0; j < nb; j++) begin
			tb_mosi <= d[7 - j];
			repeat (5) @(posedge pclk);
			if (cm) chk("miso bit", miso_w, e[7 - j]);
			tb_sck <= 1'b1;
			repeat (4) @(posedge pclk);
			tb_sck <= 1'b0;
		end
		repeat (4) @(posedge pclk);
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		rd("ctrl rst", SMSC_OFF_CTRL, 32'h0);
		rd("stat rst", SMSC_OFF_STAT, 32'h0);
		rd("data rst", SMSC_OFF_DATA, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", {31'h0, err_v}, 32'h1);
		wr(SMSC_OFF_STAT, 8'hff);
		rd("stat ro", SMSC_OFF_STAT, 32'h1);
		wr(SMSC_OFF_CTRL, 8'h10);
		wr(SMSC_OFF_PDIR, 8'h0d);
		wr(SMSC_OFF_DATA, 8'h77);
		repeat (40) @(posedge pclk);
		rd("disabled", SMSC_OFF_STAT, 32'h1);
	endtask

	task automatic t_master;
		logic [7:0] d;
		logic l;
		int h;
		for (i = 0; i < 8; i++) begin
			d = 8'h96 ^ 8'(i * 37);
			l = i[2] ^ i[0];
			pcpol <= i[0];
			pcpha <= i[1];
			plsb <= l;
			ptx <= ~d;
			wr(SMSC_OFF_CTRL, {2'b01, l, 1'b1, i[0], i[1], i[1:0]});
			wr(SMSC_OFF_STAT, {7'h00, i[2]});
			wr(SMSC_OFF_PDIR, 8'h1d);
			wr(SMSC_OFF_PDIR, 8'h0d);
			chk("sck idle", sck_w, i[0]);
			wr(SMSC_OFF_DATA, d);
			h = 0;
			while (sck_out.o === i[0] && h < 300) begin
				@(posedge pclk);
				h++;
			end
			h = 0;
			while (sck_out.o !== i[0] && h < 300) begin
				@(posedge pclk);
				h++;
			end
			chk("half period", h, dv[i] / 2);
			wait_tcf;
			chk("done stat", rd_v, 32'h80 | 32'(i[2]));
			rd("rx data", SMSC_OFF_DATA, {24'h0, ~d});
			chk("peer rx", prx, d);
			rd("stat clear", SMSC_OFF_STAT, 32'(i[2]));
		end
	endtask

	task automatic t_flags;
		pcpol <= 1'b0;
		pcpha <= 1'b0;
		plsb <= 1'b0;
		wr(SMSC_OFF_CTRL, 8'hd0);
		wr(SMSC_OFF_STAT, 8'h00);
		// Reframe the peer so the polarity change does not skew its count
		wr(SMSC_OFF_PDIR, 8'h1d);
		wr(SMSC_OFF_PDIR, 8'h0d);
		ptx <= 8'h33;
		wr(SMSC_OFF_DATA, 8'h5a);
		wr(SMSC_OFF_DATA, 8'ha5);
		wait_tcf;
		chk("collision", rd_v, 32'hc0);
		chk("irq masked", irq, 1'b0);
		gie <= 1'b1;
		@(posedge pclk);
		chk("irq on", irq, 1'b1);
		irq_ack <= 1'b1;
		@(posedge pclk);
		irq_ack <= 1'b0;
		@(posedge pclk);
		chk("irq ack", irq, 1'b0);
		rd("ack stat", SMSC_OFF_STAT, 32'h40);
		rd("first kept", SMSC_OFF_DATA, 32'h33);
		chk("peer first", prx, 8'h5a);
		rd("write_collision_flag clear", SMSC_OFF_STAT, 32'h0);
		gie <= 1'b0;
	endtask

	task automatic t_fault;
		wr(SMSC_OFF_CTRL, 8'h50);
		wr(SMSC_OFF_PDIR, 8'h05);
		tb_ss_n <= 1'b0;
		repeat (4) @(posedge pclk);
		rd("fault ctrl", SMSC_OFF_CTRL, 32'h40);
		chk("mosi oe", mosi_out.oe, 1'b0);
		chk("sck oe", sck_out.oe, 1'b0);
		rd("fault stat", SMSC_OFF_STAT, 32'h80);
		apb(1'b0, SMSC_OFF_DATA, 32'h0);
		tb_ss_n <= 1'b1;
		repeat (3) @(posedge pclk);
		wr(SMSC_OFF_CTRL, 8'h50);
		rd("remaster", SMSC_OFF_CTRL, 32'h50);
		rd("fault clr", SMSC_OFF_STAT, 32'h0);
	endtask

	task automatic t_slave;
		wr(SMSC_OFF_CTRL, 8'h40);
		wr(SMSC_OFF_PDIR, 8'h02);
		wr(SMSC_OFF_DATA, 8'h3c);
		chk("miso oe idle", miso_out.oe, 1'b0);
		sbyte(8'hff, 8, 1'b0, 8'h00);
		rd("passive", SMSC_OFF_STAT, 32'h0);
		tb_ss_n <= 1'b0;
		sbyte(8'ha6, 8, 1'b1, 8'h3c);
		tb_ss_n <= 1'b1;
		wait_tcf;
		chk("slave tcf", rd_v, 32'h80);
		rd("slave data", SMSC_OFF_DATA, 32'ha6);
		tb_ss_n <= 1'b0;
		sbyte(8'h55, 3, 1'b0, 8'h00);
		tb_ss_n <= 1'b1;
		repeat (4) @(posedge pclk);
		tb_ss_n <= 1'b0;
		sbyte(8'hc3, 8, 1'b0, 8'h00);
		tb_ss_n <= 1'b1;
		wait_tcf;
		rd("abort data", SMSC_OFF_DATA, 32'hc3);
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_master;
		t_flags;
		t_fault;
		t_slave;
		end_sim;
	end

	initial begin
		#200000;
		num_errors++;
		end_sim;
	end
endmodule
